// File: tb/lamp_chk.sv
module lamp_chk
   import lamp_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES
) (
   input wire logic         clk_i,
   input wire logic         sys_rst_i,
   input wire logic [7:0]   reg_addr_i,
   input wire logic [31:0]  reg_wdata_i,
   input wire logic         reg_wr_i,
   input wire logic         port0_link_i,
   input wire logic         port1_link_i,
   input wire logic         port0_frame_i,
   input wire duo_lamp_type slave_lamp_o,
   input wire duo_lamp_type run_lamp_o,
   input wire duo_lamp_type fault_lamp_o,
   input wire duo_lamp_type comm0_lamp_o,
   input wire duo_lamp_type comm1_lamp_o,
   input wire logic         port0_link_lamp_o,
   input wire logic         port1_link_lamp_o,
   input wire logic         port0_traffic_lamp_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [6:0] ms_q;
   logic [2:0] cs_q;
   int         age_q;
   int         quiet_q;
   int         on_q;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   // Shadow status words; age gives the lamps time to settle
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ms_q    <= 7'h00;
         cs_q    <= 3'h0;
         age_q   <= 0;
         quiet_q <= 0;
         on_q    <= 0;
      end else begin
         age_q   <= reg_wr_i ? 0 : age_q + 1;
         quiet_q <= port0_frame_i ? 0 : quiet_q + 1;
         on_q    <= port0_traffic_lamp_o ? on_q + 1 : 0;
         if (reg_wr_i && reg_addr_i == MASTER_STAT_OFS)
            ms_q <= reg_wdata_i[6:0];
         if (reg_wr_i && reg_addr_i == CLIENT_STAT_OFS)
            cs_q <= reg_wdata_i[2:0];
      end
   end

   link0_lamp_a: assert property (
      $stable(port0_link_i) [*4] |-> port0_link_lamp_o == port0_link_i)
      else $error("link 0 lamp wrong");
   link1_lamp_a: assert property (
      $stable(port1_link_i) [*4] |-> port1_link_lamp_o == port1_link_i)
      else $error("link 1 lamp wrong");
   traffic_quiet_a: assert property (
      quiet_q > 210 * TICK_LEN |-> !port0_traffic_lamp_o)
      else $error("traffic lamp lit without frames");
   flicker_on_a: assert property (
      port0_traffic_lamp_o |-> on_q <= 51 * TICK_LEN)
      else $error("traffic lamp lit too long");
   master0_steady_a: assert property (
      age_q > 4 && ms_q[1:0] == 2'h1
      |-> comm0_lamp_o == (ms_q[2] ? 2'h2 : 2'h1))
      else $error("channel 0 steady lamp wrong");
   master1_steady_a: assert property (
      age_q > 4 && ms_q[5:4] == 2'h1
      |-> comm1_lamp_o == (ms_q[6] ? 2'h2 : 2'h1))
      else $error("channel 1 steady lamp wrong");
   fault_red_a: assert property (
      age_q > 4 && cs_q[2] |-> fault_lamp_o == 2'h2)
      else $error("fault lamp not red");
   run_green_a: assert property (
      age_q > 4 && cs_q == 3'h3 |-> run_lamp_o == 2'h1)
      else $error("run lamp not green");
   reset_dark_a: assert property (
      $fell(sys_rst_i) |-> {slave_lamp_o, run_lamp_o, fault_lamp_o,
         comm0_lamp_o, comm1_lamp_o, port0_link_lamp_o} == 11'h000)
      else $error("lamps lit after reset");

   // Main scenarios reached
   cover property (comm0_lamp_o == 2'h2);
   cover property ($rose(port0_traffic_lamp_o));
   cover property (slave_lamp_o == 2'h3);
endmodule

bind status_led_pattern_generator lamp_chk #(.TICK_LEN(TICK_LEN)) chk_u (
   .clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .port0_link_i,
   .port1_link_i, .port0_frame_i, .slave_lamp_o, .run_lamp_o,
   .fault_lamp_o, .comm0_lamp_o, .comm1_lamp_o, .port0_link_lamp_o,
   .port1_link_lamp_o, .port0_traffic_lamp_o);

// File: tb/lamp_meter.sv
module lamp_meter (
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   input  wire logic lamp_i,
   output int        on_len_o,
   output int        off_len_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic prev_q;
   int   run_q;

   // Log each finished lit or dark run; a steady lamp logs nothing new
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         prev_q    <= 1'b0;
         run_q     <= 0;
         on_len_o  <= 0;
         off_len_o <= 0;
      end else if (lamp_i == prev_q) begin
         run_q <= run_q + 1;
      end else begin
         prev_q <= lamp_i;
         run_q  <= 1;
         if (prev_q)
            on_len_o <= run_q;
         else
            off_len_o <= run_q;
      end
   end
endmodule

// File: tb/status_led_pattern_generator_test.sv
module status_led_pattern_generator_test
   import lamp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int T = 2; // Short tick keeps three-second patterns cheap
   logic         clk_i = 1'b0;
   logic         sys_rst_i = 1'b1;
   logic [7:0]   reg_addr_i = 8'h00;
   logic [31:0]  reg_wdata_i = 32'h0000_0000;
   logic         reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic         port0_link_i = 1'b0, port1_link_i = 1'b0;
   logic         port0_frame_i = 1'b0, port1_frame_i = 1'b0;
   logic [2:0]   sel = 3'h0;
   logic [31:0]  reg_rdata_o;
   duo_lamp_type slave_lamp_o, run_lamp_o, fault_lamp_o;
   duo_lamp_type comm0_lamp_o, comm1_lamp_o;
   logic         port0_link_lamp_o, port1_link_lamp_o;
   logic         port0_traffic_lamp_o, port1_traffic_lamp_o;
   int           on_len, off_len, cyc = 0, compares = 0, miscompares = 0;

   // Pick the lamp under measurement
   wire [6:0] pick = {port0_traffic_lamp_o, fault_lamp_o.red,
      run_lamp_o.green, slave_lamp_o.green, comm1_lamp_o.green,
      comm0_lamp_o.red, comm0_lamp_o.green};
   wire       watch = pick[sel];

   status_led_pattern_generator #(.TICK_LEN(T)) dut_u (
      .clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .port0_link_i, .port1_link_i, .port0_frame_i,
      .port1_frame_i, .slave_lamp_o, .run_lamp_o, .fault_lamp_o,
      .comm0_lamp_o, .comm1_lamp_o, .port0_link_lamp_o, .port1_link_lamp_o,
      .port0_traffic_lamp_o, .port1_traffic_lamp_o);
   lamp_meter meter_u (.clk_i, .sys_rst_i, .lamp_i(watch),
      .on_len_o(on_len), .off_len_o(off_len));

   always #2 clk_i = ~clk_i;

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Ends one ns past the edge so outputs have settled
   task automatic ticks(input int n);
      repeat (n * T) @(posedge clk_i);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1;
      check(reg_rdata_o, exp);
      @(posedge clk_i);
   endtask

   task automatic measure(input logic [2:0] s, input int on, input int off,
                          input int w);
      sel <= s;
      ticks(w);
      check(32'(on_len), 32'(on * T));
      check(32'(off_len), 32'(off * T));
   endtask

   task automatic pulse;
      @(posedge clk_i);
      port0_frame_i <= 1'b1;
      port1_frame_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      port0_frame_i <= 1'b0;
      port1_frame_i <= 1'b0;
   endtask

   task automatic t_regs;
      rd_chk(SLAVE_PHASE_OFS, 32'h0000_0000);
      wr(SLAVE_PHASE_OFS, 32'hFFFF_FFF5);
      rd_chk(SLAVE_PHASE_OFS, 32'h0000_0005);
      wr(MASTER_STAT_OFS, 32'hFFFF_FFFF);
      rd_chk(MASTER_STAT_OFS, 32'h0000_0077);
      wr(CLIENT_STAT_OFS, 32'hFFFF_FFFF);
      rd_chk(CLIENT_STAT_OFS, 32'h0000_0007);
      rd_chk(8'h10, 32'h0000_0000);
      $display("test regs done");
   endtask

   task automatic t_master;
      wr(MASTER_STAT_OFS, 32'h0000_0024);
      measure(3'd1, 100, 100, 700);
      measure(3'd2, 100, 100, 500);
      wr(MASTER_STAT_OFS, 32'h0000_0003);
      ticks(300);
      check(32'(comm0_lamp_o.red), 32'h0);
      wr(MASTER_STAT_OFS, 32'h0000_0051);
      ticks(5);
      check({28'h0, comm0_lamp_o, comm1_lamp_o}, 32'h6);
      rd_chk(LAMP_VIEW_OFS, 32'h0000_0265);
      @(posedge clk_i);
      sys_rst_i <= 1'b1;
      #1 check({28'h0, comm0_lamp_o, comm1_lamp_o}, 32'h0);
      @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      rd_chk(MASTER_STAT_OFS, 32'h0000_0000);
      $display("test master done");
   endtask

   task automatic t_client;
      wr(CLIENT_STAT_OFS, 32'h0000_0001);
      measure(3'd4, 100, 100, 500);
      wr(CLIENT_STAT_OFS, 32'h0000_0000);
      measure(3'd5, 100, 100, 500);
      check(32'(run_lamp_o), 32'h0);
      wr(CLIENT_STAT_OFS, 32'h0000_0003);
      ticks(5);
      check({28'h0, run_lamp_o, fault_lamp_o}, 32'h4);
      wr(CLIENT_STAT_OFS, 32'h0000_0007);
      ticks(5);
      check(32'(fault_lamp_o), 32'h2);
      $display("test client done");
   endtask

   // Sample each three-second pattern in the middle of every slot
   task automatic t_slave;
      logic [3:0]  code [5] = '{4'h2, 4'h3, 4'h4, 4'h7, 4'h8};
      logic [11:0] mask [5] = '{12'h001, 12'h005, 12'h015, 12'h001, 12'h005};
      logic [31:0] e;
      for (int k = 0; k < 5; k++) begin
         wr(SLAVE_PHASE_OFS, {28'h0, code[k]});
         ticks(126);
         for (int i = 0; i < 13; i++) begin
            e = (mask[k][i % 12] ^ (k > 2)) ? 32'h1 : 32'h3;
            check(32'(slave_lamp_o), e);
            ticks(250);
         end
      end
      wr(SLAVE_PHASE_OFS, 32'h0000_0009);
      measure(3'd3, 250, 250, 1100);
      wr(SLAVE_PHASE_OFS, 32'h0000_000B);
      measure(3'd3, 250, 250, 1100);
      check(32'(slave_lamp_o.red ^ slave_lamp_o.green), 32'h1);
      wr(SLAVE_PHASE_OFS, 32'h0000_000A);
      measure(3'd3, 250, 250, 1100);
      check(32'(slave_lamp_o.red ^ slave_lamp_o.green), 32'h0);
      $display("test slave done");
   endtask

   task automatic t_ports;
      @(posedge clk_i);
      port0_link_i <= 1'b1;
      ticks(5);
      check({30'h0, port0_link_lamp_o, port1_link_lamp_o}, 32'h2);
      @(posedge clk_i);
      port0_link_i <= 1'b0;
      port1_link_i <= 1'b1;
      ticks(5);
      check({30'h0, port0_link_lamp_o, port1_link_lamp_o}, 32'h1);
      sel <= 3'd6;
      repeat (20) begin
         pulse();
         ticks(20);
      end
      check(32'(on_len), 32'(50 * T));
      check(32'(off_len), 32'(50 * T));
      ticks(250);
      check({30'h0, port0_traffic_lamp_o, port1_traffic_lamp_o}, 32'h0);
      pulse();
      ticks(10);
      check(32'(port0_traffic_lamp_o), 32'h1);
      ticks(140);
      check(32'(port0_traffic_lamp_o), 32'h0);
      $display("test ports done");
   endtask

   task automatic end_of_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Cut a hung run short; the tests need about 47000 cycles
   always @(posedge clk_i) begin
      cyc = cyc + 1;
      if (cyc == 60000) begin
         miscompares = miscompares + 1;
         end_of_test();
      end
   end

   initial begin
      repeat (12) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_master();
      t_client();
      t_slave();
      t_ports();
      end_of_test();
   end
endmodule

// File: verilog/lamp_pkg.sv
// Functional notes
// (R1) 2 Hz single colour: 250 ms on/off
// (R2) 2 Hz two colours: alternate, 250 ms each
// (R3) One green 250 ms, orange 2750 ms
// (R4) Green/orange/green, orange hold 2250 ms
// (R5) Three greens alternating, orange hold 1750 ms
// (R6) One orange 250 ms, green 2750 ms
// (R7) Orange/green/orange, green hold 2250 ms
// (R8) Heavy traffic flicker: 50 ms on/off
// (R9) Light traffic flicker follows single frames
// (R10) 5 Hz blink: 100 ms on/off
// (R11) Run lamp: green, 5 Hz green, off
// (R12) Fault lamp: off, 5 Hz red, red
// (R13) Link lamp lit while port linked
// (R14) Traffic lamp flickers with frames, else off
// (R15) Master lamp green: all slaves connected
// (R16) Master lamp 5 Hz green: not released
// (R17) Master lamp irregular green: bad configuration
// (R18) Master lamp 5 Hz red: slave lost
// (R19) Master lamp red: all lost, serious error
// (R20) One independent lamp per fieldbus channel
// (R21) Slave phases map to three-second patterns
// (R22) Millisecond tick, restart on change, reset dark
package lamp_pkg;

   // Clock and tick timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int TICK_NS       = 1_000_000;
   localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

   // Pattern times in milliseconds
   localparam logic [11:0] FLASH2_MS = 12'd250;
   localparam logic [11:0] BLINK5_MS = 12'd100;
   localparam logic [11:0] FLICK_MS  = 12'd50;
   localparam logic [11:0] SLOT_MS   = 12'd250;
   localparam logic [11:0] CYCLE_MS  = 12'd3000;
   localparam logic [11:0] ACYC_MS   = 12'd100;

   // Register offsets and reset values
   localparam logic [7:0]  SLAVE_PHASE_OFS = 8'h00;
   localparam logic [7:0]  CLIENT_STAT_OFS = 8'h04;
   localparam logic [7:0]  MASTER_STAT_OFS = 8'h08;
   localparam logic [7:0]  LAMP_VIEW_OFS   = 8'h0C;
   localparam logic [3:0]  SLAVE_PHASE_RST = 4'h0;
   localparam logic [2:0]  CLIENT_STAT_RST = 3'h0;
   localparam logic [2:0]  MASTER_STAT_RST = 3'h0;
   localparam logic [15:0] LFSR_SEED       = 16'hACE1;

   // Field positions
   localparam int CFG_BIT  = 0;
   localparam int ACT_BIT  = 1;
   localparam int ERR_BIT  = 2;
   localparam int MCH1_POS = 4;

   localparam int NUM_DUO = 5;

   // Lamp patterns
   typedef enum logic [3:0] {
      PAT_OFF, PAT_GREEN, PAT_RED, PAT_ORANGE,
      PAT_F2_G, PAT_F2_O, PAT_F2_GR, PAT_BL5_G, PAT_BL5_R,
      PAT_G1, PAT_G2, PAT_G3, PAT_O1, PAT_O2, PAT_ACYC_G
   } pat_type;

   // Slave phase codes
   typedef enum logic [3:0] {
      SL_NRT, SL_PHASE_ZERO, SL_PHASE_ONE, SL_PHASE_TWO,
      PHASE_THREE, SL_PHASE_FOUR, SL_HOTPLUG_ZERO,
      HOTPLUG_PHASE_ONE, SL_HOTPLUG_TWO, SL_LOOPBACK,
      SL_IDENTIFY, SL_WARNING, SL_COMM_ERROR
   } slave_phase_type;

   // Fieldbus master channel codes
   typedef enum logic [2:0] {
      MS_OFF, MS_ALL_OK, MS_NOT_RELEASED, MS_BAD_CONFIG,
      MS_SLAVE_LOST, MS_SERIOUS
   } master_state_type;

   typedef struct packed {
      logic red;
      logic green;
   } duo_lamp_type;

endpackage

// File: verilog/status_led_pattern_generator.sv
module status_led_pattern_generator
   import lamp_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES
) (
   input  wire logic         clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic [7:0]   reg_addr_i,
   input  wire logic [31:0]  reg_wdata_i,
   input  wire logic         reg_wr_i,
   input  wire logic         reg_rd_i,
   output logic [31:0]       reg_rdata_o,
   input  wire logic         port0_link_i,
   input  wire logic         port1_link_i,
   input  wire logic         port0_frame_i,
   input  wire logic         port1_frame_i,
   output duo_lamp_type      slave_lamp_o,
   output duo_lamp_type      run_lamp_o,
   output duo_lamp_type      fault_lamp_o,
   output duo_lamp_type      comm0_lamp_o,
   output duo_lamp_type      comm1_lamp_o,
   output logic              port0_link_lamp_o,
   output logic              port1_link_lamp_o,
   output logic              port0_traffic_lamp_o,
   output logic              port1_traffic_lamp_o
);

   // Period of each pattern in ticks; steady ones never advance
   // A period of one wraps the counter on every tick
   function automatic logic [11:0] period_of(input pat_type p);
      logic [11:0] r;
      r = 12'd1;
      unique case (p)
         PAT_F2_G, PAT_F2_O, PAT_F2_GR: r = FLASH2_MS + FLASH2_MS;
         PAT_BL5_G, PAT_BL5_R:          r = BLINK5_MS + BLINK5_MS;
         PAT_G1, PAT_G2, PAT_G3,
         PAT_O1, PAT_O2:                r = CYCLE_MS;
         PAT_ACYC_G:                    r = ACYC_MS;
         default:                       r = 12'd1;
      endcase
      return r;
   endfunction

   // Colour of a pattern at a given position in its period
   // Orange is both dies lit, so no colour mixing is needed
   function automatic duo_lamp_type colour_of(input pat_type     p,
                                              input logic [11:0] c,
                                              input logic        rnd);
      duo_lamp_type g;
      duo_lamp_type o;
      duo_lamp_type rd;
      duo_lamp_type dk;
      duo_lamp_type r;
      logic [11:0]  slot;
      logic         h2;
      logic         h5;
      logic         even;
      g    = '{red: 1'b0, green: 1'b1};
      o    = '{red: 1'b1, green: 1'b1};
      rd   = '{red: 1'b1, green: 1'b0};
      dk   = '{red: 1'b0, green: 1'b0};
      r    = dk;
      slot = c / SLOT_MS;
      h2   = (c < FLASH2_MS);
      h5   = (c < BLINK5_MS);
      even = ~slot[0];
      unique case (p)
         PAT_OFF:    r = dk;
         PAT_GREEN:  r = g;
         PAT_RED:    r = rd;
         PAT_ORANGE: r = o;
         PAT_F2_G:   r = h2 ? g : dk;                   // R1
         PAT_F2_O:   r = h2 ? o : dk;                   // R1
         PAT_F2_GR:  r = h2 ? g : rd;                   // R2
         PAT_BL5_G:  r = h5 ? g : dk;                   // R10
         PAT_BL5_R:  r = h5 ? rd : dk;                  // R10
         PAT_G1:     r = (slot < 12'd1 && even) ? g : o; // R3
         PAT_G2:     r = (slot < 12'd3 && even) ? g : o; // R4
         PAT_G3:     r = (slot < 12'd5 && even) ? g : o; // R5
         PAT_O1:     r = (slot < 12'd1 && even) ? o : g; // R6
         PAT_O2:     r = (slot < 12'd3 && even) ? o : g; // R7
         PAT_ACYC_G: r = rnd ? g : dk;                  // R17
         default:    r = dk;
      endcase
      return r;
   endfunction

   // Slave phase to pattern
   // Spare codes go dark rather than show a guessed pattern
   function automatic pat_type slave_pat(input logic [3:0] ph);
      pat_type r;
      r = PAT_OFF;
      unique case (ph)
         SL_PHASE_ZERO:     r = PAT_ORANGE;
         SL_PHASE_ONE:      r = PAT_G1;                 // R21
         SL_PHASE_TWO:      r = PAT_G2;                 // R21
         PHASE_THREE:       r = PAT_G3;                 // R21
         SL_PHASE_FOUR:     r = PAT_GREEN;
         SL_HOTPLUG_ZERO:   r = PAT_F2_O;
         HOTPLUG_PHASE_ONE: r = PAT_O1;                 // R21
         SL_HOTPLUG_TWO:    r = PAT_O2;                 // R21
         SL_LOOPBACK:       r = PAT_F2_G;
         SL_IDENTIFY:       r = PAT_F2_O;
         SL_WARNING:        r = PAT_F2_GR;
         SL_COMM_ERROR:     r = PAT_RED;
         default:           r = PAT_OFF;
      endcase
      return r;
   endfunction

   // Fieldbus master state to pattern
   // Codes six and seven are spare and leave the lamp dark
   function automatic pat_type master_pat(input logic [2:0] st);
      pat_type r;
      r = PAT_OFF;
      unique case (st)
         MS_ALL_OK:       r = PAT_GREEN;                // R15
         MS_NOT_RELEASED: r = PAT_BL5_G;                // R16
         MS_BAD_CONFIG:   r = PAT_ACYC_G;               // R17
         MS_SLAVE_LOST:   r = PAT_BL5_R;                // R18
         MS_SERIOUS:      r = PAT_RED;                  // R19
         default:         r = PAT_OFF;
      endcase
      return r;
   endfunction

   // Software-written status
   // Held until the next write; firmware owns the meaning
   logic [3:0]  slave_phase_q;
   logic [2:0]  client_stat_q;
   logic [2:0]  master0_q;
   logic [2:0]  master1_q;
   logic [31:0] rdata_q;

   // Pin synchronisers: meta stage, stable stage, edge history
   logic [3:0]  pin_meta_q;
   logic [3:0]  pin_sync_q;
   logic [1:0]  frame_old_q;
   logic [1:0]  link_lamp_q;

   // Tick divider and pseudo-random source
   logic [31:0] div_q;
   logic        tick_q;
   logic [15:0] lfsr_q;

   // Register decode
   // Exact offset match; an alias would hide a software bug
   wire wr_slave  = reg_wr_i && (reg_addr_i == SLAVE_PHASE_OFS);
   wire wr_client = reg_wr_i && (reg_addr_i == CLIENT_STAT_OFS);
   wire wr_master = reg_wr_i && (reg_addr_i == MASTER_STAT_OFS);

   duo_lamp_type lamp_q   [NUM_DUO];
   pat_type      pat_sel  [NUM_DUO];
   logic [1:0]   traffic_q;
   logic [31:0]  view_word;
   logic [31:0]  read_mux;

   // Status read-back of every lamp
   // Bits above the traffic lamps read zero, room to grow
   assign view_word = {18'h0, traffic_q, link_lamp_q,
                       lamp_q[4], lamp_q[3], lamp_q[2],
                       lamp_q[1], lamp_q[0]};

   // Unmapped offsets read as zero
   // Reads have no side effect, so a stray strobe is harmless
   assign read_mux =
      (reg_addr_i == SLAVE_PHASE_OFS) ? {28'h0, slave_phase_q} :
      (reg_addr_i == CLIENT_STAT_OFS) ? {29'h0, client_stat_q} :
      (reg_addr_i == MASTER_STAT_OFS) ?
         {25'h0, master1_q, 1'b0, master0_q} :
      (reg_addr_i == LAMP_VIEW_OFS)   ? view_word : 32'h0;

   // Register writes
   // Narrow fields take the low bits, master channel 1 takes bits 6:4; the rest are dropped
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         slave_phase_q <= SLAVE_PHASE_RST;
         client_stat_q <= CLIENT_STAT_RST;
         master0_q     <= MASTER_STAT_RST;
         master1_q     <= MASTER_STAT_RST;
      end else begin
         if (wr_slave) begin
            slave_phase_q <= reg_wdata_i[3:0];
         end
         if (wr_client) begin
            client_stat_q <= reg_wdata_i[2:0];
         end
         if (wr_master) begin
            master0_q <= reg_wdata_i[2:0];
            master1_q <= reg_wdata_i[MCH1_POS +: 3];
         end
      end
   end

   // Read data stands only in the cycle after the strobe
   // Zero between reads, so a stale word is never taken
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_q <= 32'h0;
      end else begin
         rdata_q <= reg_rd_i ? read_mux : 32'h0;
      end
   end

   // Two flops on every pin before use
   // Link lamp is a third stage so it leaves from a flop
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_meta_q  <= 4'h0;
         pin_sync_q  <= 4'h0;
         frame_old_q <= 2'h0;
         link_lamp_q <= 2'h0;
      end else begin
         pin_meta_q  <= {port1_frame_i, port0_frame_i,
                         port1_link_i, port0_link_i};
         pin_sync_q  <= pin_meta_q;
         frame_old_q <= pin_sync_q[3:2];
         link_lamp_q <= pin_sync_q[1:0];             // R13
      end
   end

   // A frame is a rising edge on the synchronised frame pin
   // History resets low like the idle pin: no false frame
   wire [1:0] frame_ev = pin_sync_q[3:2] & ~frame_old_q;

   // Millisecond tick; long count is a parameter for short sims
   // All engines count this one tick, so lamps stay in step
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         div_q  <= 32'h0;
         tick_q <= 1'b0;
      end else if (div_q == 32'(TICK_LEN - 1)) begin
         div_q  <= 32'h0;
         tick_q <= 1'b1;                             // R22
      end else begin
         div_q  <= div_q + 32'h1;
         tick_q <= 1'b0;
      end
   end

   // Irregular source for the acyclic pattern
   // Steps once per tick so the blips are slow enough to see
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         lfsr_q <= LFSR_SEED;
      end else if (tick_q) begin
         lfsr_q <= {lfsr_q[14:0],
                    lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      end
   end

   // Pattern selection per duo lamp
   wire cfg = client_stat_q[CFG_BIT];
   wire act = client_stat_q[ACT_BIT];
   wire err = client_stat_q[ERR_BIT];

   // Slave lamp follows the phase code alone
   assign pat_sel[0] = slave_pat(slave_phase_q);
   // Unconfigured run lamp is dark whatever the activity bit
   assign pat_sel[1] = !cfg ? PAT_OFF :
                       act  ? PAT_GREEN : PAT_BL5_G;  // R11
   // An error outranks the configuration state
   assign pat_sel[2] = err ? PAT_RED :
                       cfg ? PAT_OFF : PAT_BL5_R;     // R12
   assign pat_sel[3] = master_pat(master0_q);         // R20
   assign pat_sel[4] = master_pat(master1_q);         // R20

   // One pattern engine per duo lamp
   genvar i;
   generate
      for (i = 0; i < NUM_DUO; i++) begin : g_duo
         pat_type     pat_q;
         logic [11:0] cnt_q;
         logic        rnd_q;
         wire  [11:0] per  = period_of(pat_q);
         wire         chg  = (pat_sel[i] != pat_q);
         wire         wrap = (cnt_q >= per - 12'd1);

         // Restart from step zero whenever the selection changes
         // Random bit reloaded so a restart starts fresh
         always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               pat_q <= PAT_OFF;
               cnt_q <= 12'h0;
               rnd_q <= 1'b0;
            end else if (chg) begin
               pat_q <= pat_sel[i];                 // R22
               cnt_q <= 12'h0;
               rnd_q <= lfsr_q[i];
            end else if (tick_q) begin
               if (wrap) begin
                  cnt_q <= 12'h0;
                  rnd_q <= lfsr_q[i];
               end else begin
                  cnt_q <= cnt_q + 12'h1;
               end
            end
         end

         // Lamp flop; dark during reset
         // Decode is combinational; the flop hides its hazards
         always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               lamp_q[i] <= '{red: 1'b0, green: 1'b0}; // R22
            end else begin
               lamp_q[i] <= colour_of(pat_q, cnt_q, rnd_q);
            end
         end
      end
   endgenerate

   // Traffic flicker per port. A 100 ms cycle starts on a frame
   // and repeats only if another frame came meanwhile, so heavy
   // traffic gives a steady 10 Hz and light traffic single blips.
   // Heavier traffic can never raise the rate above 10 Hz.
   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : g_traffic
         logic       run_q;
         logic       seen_q;
         logic [6:0] fcnt_q;
         wire        last = (fcnt_q == 7'(FLICK_MS + FLICK_MS - 1));
         wire        any  = seen_q | frame_ev[p];

         always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               run_q  <= 1'b0;
               seen_q <= 1'b0;
               fcnt_q <= 7'h0;
            end else if (tick_q && run_q && last) begin
               run_q  <= any;                        // R8
               seen_q <= frame_ev[p];
               fcnt_q <= 7'h0;
            end else if (tick_q && run_q) begin
               seen_q <= any;
               fcnt_q <= fcnt_q + 7'h1;
            end else if (!run_q && any) begin
               run_q  <= 1'b1;                       // R9
               seen_q <= 1'b0;
               fcnt_q <= 7'h0;
            end else begin
               // A frame arriving now is kept
               seen_q <= any;
            end
         end

         // Lit in the first half of each running cycle
         // A cycle is never cut short, so each blip is visible
         always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               traffic_q[p] <= 1'b0;
            end else begin
               traffic_q[p] <= run_q &&
                               (fcnt_q < 7'(FLICK_MS)); // R14
            end
         end
      end
   endgenerate

   // Outputs straight from flops
   // Nothing decoded on the way out, so lamps cannot glitch
   assign reg_rdata_o          = rdata_q;
   assign slave_lamp_o         = lamp_q[0];
   assign run_lamp_o           = lamp_q[1];
   assign fault_lamp_o         = lamp_q[2];
   assign comm0_lamp_o         = lamp_q[3];
   assign comm1_lamp_o         = lamp_q[4];
   assign port0_link_lamp_o    = link_lamp_q[0];
   assign port1_link_lamp_o    = link_lamp_q[1];
   assign port0_traffic_lamp_o = traffic_q[0];
   assign port1_traffic_lamp_o = traffic_q[1];

endmodule
